// file: gpio_pkg.sv
// Purpose: shared constants, carrier types and helpers for the gpio pin interrupt unit
// Assumes: 32 pins, half ports of 8 pins, AHB-Lite word registers
// Notes: all offsets are byte addresses inside a 4 KB window
package gpio_pkg;
    localparam int NPINS = 32;
    localparam int HP_W = 8;
    localparam int NHP = NPINS / HP_W;
    localparam int N_FUNC = 4;
    localparam int FSEL_W = 2;
    localparam int CH_SHIFT = 6;
    // port registers
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_DATA_SET = 12'h004;
    localparam logic [11:0] OFF_DATA_CLR = 12'h008;
    localparam logic [11:0] OFF_DATA_TGL = 12'h00c;
    localparam logic [11:0] OFF_DIR = 12'h010;
    localparam logic [11:0] OFF_DIR_SET = 12'h014;
    localparam logic [11:0] OFF_DIR_CLR = 12'h018;
    localparam logic [11:0] OFF_PIN_STATE = 12'h01c;
    localparam logic [11:0] OFF_IMASK = 12'h020;
    localparam logic [11:0] OFF_ISTAT = 12'h024;
    localparam logic [11:0] OFF_ISENS = 12'h028;
    localparam logic [11:0] OFF_IBOTH = 12'h02c;
    localparam logic [11:0] OFF_FUNC_EN = 12'h030;
    localparam logic [11:0] OFF_FMUX_LO = 12'h034;
    localparam logic [11:0] OFF_FMUX_HI = 12'h038;
    localparam logic [11:0] CH_BASE = 12'h100;
    // pin interrupt channel registers, relative to the channel base
    localparam logic [5:0] CH_ASSIGN = 6'h00;
    localparam logic [5:0] CH_MASK_SET = 6'h04;
    localparam logic [5:0] CH_MASK_CLR = 6'h08;
    localparam logic [5:0] CH_REQ = 6'h0c;
    localparam logic [5:0] CH_LATCH = 6'h10;
    localparam logic [5:0] CH_EDGE_SET = 6'h14;
    localparam logic [5:0] CH_EDGE_CLR = 6'h18;
    localparam logic [5:0] CH_INV_SET = 6'h1c;
    localparam logic [5:0] CH_INV_CLR = 6'h20;
    localparam logic [5:0] CH_PINS = 6'h24;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic en;
        logic [5:0] off;
        logic [31:0] data;
    } ch_wr_t;

    typedef enum logic [0:0] {
        BUS_READY = 1'b0,
        BUS_RD_WAIT = 1'b1
    } bus_state_t;

    // write-one-to-set / write-one-to-clear update
    function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic s,
                                            input logic c, input logic [31:0] d);
        set_clr = s ? (cur | d) : (c ? (cur & ~d) : cur);
    endfunction
endpackage

// file: pin_irq_channel.sv
// Purpose: one pin interrupt channel gathering half ports into one request
// Assumes: pins are synchronous to hclk; writes arrive as a one-cycle strobe
// Notes: read data is combinational from the stored state, except CH_PINS, which reads the live pins
`timescale 1ns/1ps
module pin_irq_channel
    import gpio_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire ch_wr_t wr,
    input wire logic [NPINS-1:0] pins,
    input wire logic [5:0] rd_off,
    output logic [31:0] rd_data,
    output logic req
);
    logic [NHP-1:0] assign_reg;
    logic [31:0] mask_reg;
    logic [31:0] edge_reg;
    logic [31:0] inv_reg;
    logic [31:0] latch_reg;
    logic [31:0] active_prev_reg;
    logic [31:0] hp_en;
    logic [31:0] active;
    logic [31:0] rise;
    logic [31:0] w1c;

    for (genvar i = 0; i < NPINS; i++) begin : g_hp
        assign hp_en[i] = assign_reg[i / HP_W];
    end

    assign active = (pins ^ inv_reg) & hp_en;
    assign rise = active & ~active_prev_reg;
    assign w1c = (wr.en && (wr.off == CH_REQ || wr.off == CH_LATCH)) ? wr.data : RST_WORD;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            assign_reg <= '0;
            mask_reg <= RST_WORD;
            edge_reg <= RST_WORD;
            inv_reg <= RST_WORD;
        end else begin
            if (wr.en && wr.off == CH_ASSIGN) begin
                assign_reg <= wr.data[NHP-1:0];
            end
            mask_reg <= set_clr(mask_reg, wr.en && wr.off == CH_MASK_SET,
                                wr.en && wr.off == CH_MASK_CLR, wr.data);
            edge_reg <= set_clr(edge_reg, wr.en && wr.off == CH_EDGE_SET,
                                wr.en && wr.off == CH_EDGE_CLR, wr.data);
            inv_reg <= set_clr(inv_reg, wr.en && wr.off == CH_INV_SET,
                               wr.en && wr.off == CH_INV_CLR, wr.data);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_reg <= RST_WORD;
            active_prev_reg <= RST_WORD;
        end else begin
            active_prev_reg <= active;
            // set wins over clear on edge bits; level bits follow the pin
            latch_reg <= (edge_reg & ((latch_reg & ~w1c) | rise)) | (~edge_reg & active);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= 1'b0;
        end else begin
            req <= |(latch_reg & mask_reg);
        end
    end

    always_comb begin
        unique case (rd_off)
            CH_ASSIGN: rd_data = {{(32 - NHP){1'b0}}, assign_reg};
            CH_MASK_SET, CH_MASK_CLR: rd_data = mask_reg;
            CH_REQ: rd_data = latch_reg & mask_reg;
            CH_LATCH: rd_data = latch_reg;
            CH_EDGE_SET, CH_EDGE_CLR: rd_data = edge_reg;
            CH_INV_SET, CH_INV_CLR: rd_data = inv_reg;
            CH_PINS: rd_data = pins;
            default: rd_data = RST_WORD;
        endcase
    end

    property p_ch_req;
        @(posedge hclk) disable iff (!hresetn)
        (|(latch_reg & mask_reg)) |=> req;
    endproperty
    a_ch_req: assert property (p_ch_req) else $error("channel request not forwarded");

    property p_edge_hold;
        @(posedge hclk) disable iff (!hresetn)
        (edge_reg[9] && latch_reg[9] && !w1c[9] && $stable(edge_reg)) |=> latch_reg[9];
    endproperty
    a_edge_hold: assert property (p_edge_hold) else $error("edge latch lost");
endmodule

// file: gpio_pin_interrupt_unit.sv
// Purpose: general purpose port with pin multiplexing, port interrupts and
//          pin interrupt channels, behind an AHB-Lite slave
// Assumes: pin and peripheral inputs synchronous to hclk; word accesses only
// Notes: reads take one wait state, writes none; response is always OKAY
// Operation
// - each pin selectable as input or output
// - write-one changes only selected pin levels
// - per-pin interrupt mask; outputs trigger by software
// - level or edge; edge is rising or both
// - pin interrupts with selectable polarity
// - pin interrupts independent of port configuration
// - channel serves 32 pins, one combined request
// - half ports of eight assigned to channels
// - channel assign, mask, identify, clear registers
// - pin states and latches readable regardless mask
// - set and clear addresses for data, direction and channel mask, edge and invert registers
// - each pin muxes four peripherals plus gpio
`timescale 1ns/1ps
module gpio_pin_interrupt_unit
    import gpio_pkg::*;
#(
    parameter int N_CH = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    input wire logic [N_FUNC-1:0][NPINS-1:0] periph_out,
    input wire logic [N_FUNC-1:0][NPINS-1:0] periph_oe,
    output logic [NPINS-1:0] periph_in,
    output logic irq,
    output logic [N_CH-1:0] pin_irq
);
    bus_state_t state_reg;
    logic [11:0] addr_reg;
    logic wr_pend_reg;
    logic accept;
    logic [31:0] rd_mux;
    logic [11:0] ch_rel;
    logic [5:0] ch_idx;
    logic ch_hit;

    logic [31:0] data_reg;
    logic [31:0] dir_reg;
    logic [31:0] gmask_reg;
    logic [31:0] gstat_reg;
    logic [31:0] gsens_reg;
    logic [31:0] gboth_reg;
    logic [31:0] fen_reg;
    logic [31:0] fmux_lo_reg;
    logic [31:0] fmux_hi_reg;
    logic [31:0] src_prev_reg;
    logic [31:0] src;
    logic [31:0] gev;
    logic [31:0] gw1c;
    logic [2*NPINS-1:0] fmux;
    logic [NPINS-1:0] out_next;
    logic [NPINS-1:0] oe_next;
    logic [N_CH-1:0][31:0] ch_rd;
    logic [N_CH-1:0] ch_req;

    // bus slave
    assign accept = hsel && hready && htrans[1];
    assign ch_rel = addr_reg - CH_BASE;
    assign ch_idx = ch_rel[11:CH_SHIFT];
    assign ch_hit = (addr_reg >= CH_BASE) && (int'(ch_idx) < N_CH);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= BUS_READY;
            hreadyout <= 1'b1;
            hrdata <= RST_WORD;
            addr_reg <= 12'h000;
            wr_pend_reg <= 1'b0;
        end else begin
            wr_pend_reg <= accept && hwrite;
            if (accept) begin
                addr_reg <= haddr[11:0];
            end
            unique case (state_reg)
                BUS_READY: begin
                    if (accept && !hwrite) begin
                        state_reg <= BUS_RD_WAIT;
                        hreadyout <= 1'b0;
                    end
                end
                BUS_RD_WAIT: begin
                    state_reg <= BUS_READY;
                    hreadyout <= 1'b1;
                    hrdata <= rd_mux;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // port data and direction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_reg <= RST_WORD;
            dir_reg <= RST_WORD;
        end else if (wr_pend_reg) begin
            if (addr_reg == OFF_DATA) begin
                data_reg <= hwdata;
            end else if (addr_reg == OFF_DATA_TGL) begin
                data_reg <= data_reg ^ hwdata;
            end else begin
                data_reg <= set_clr(data_reg, addr_reg == OFF_DATA_SET,
                                    addr_reg == OFF_DATA_CLR, hwdata);
            end
            if (addr_reg == OFF_DIR) begin
                dir_reg <= hwdata;
            end else begin
                dir_reg <= set_clr(dir_reg, addr_reg == OFF_DIR_SET,
                                   addr_reg == OFF_DIR_CLR, hwdata);
            end
        end
    end

    // interrupt and mux configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gmask_reg <= RST_WORD;
            gsens_reg <= RST_WORD;
            gboth_reg <= RST_WORD;
            fen_reg <= RST_WORD;
            fmux_lo_reg <= RST_WORD;
            fmux_hi_reg <= RST_WORD;
        end else if (wr_pend_reg) begin
            unique case (addr_reg)
                OFF_IMASK: gmask_reg <= hwdata;
                OFF_ISENS: gsens_reg <= hwdata;
                OFF_IBOTH: gboth_reg <= hwdata;
                OFF_FUNC_EN: fen_reg <= hwdata;
                OFF_FMUX_LO: fmux_lo_reg <= hwdata;
                OFF_FMUX_HI: fmux_hi_reg <= hwdata;
                default: begin
                end
            endcase
        end
    end

    // port interrupt detection
    assign src = (dir_reg & data_reg) | (~dir_reg & pin_in);
    assign gev = (src & ~src_prev_reg) | (gboth_reg & ~src & src_prev_reg);
    assign gw1c = (wr_pend_reg && addr_reg == OFF_ISTAT) ? hwdata : RST_WORD;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev_reg <= RST_WORD;
            gstat_reg <= RST_WORD;
        end else begin
            src_prev_reg <= src;
            // set wins over clear; level bits follow the source
            gstat_reg <= (gsens_reg & ((gstat_reg & ~gw1c) | gev)) | (~gsens_reg & src);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(gstat_reg & gmask_reg);
        end
    end

    // pin multiplexing
    assign fmux = {fmux_hi_reg, fmux_lo_reg};

    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        logic [FSEL_W-1:0] fsel;
        assign fsel = fmux[FSEL_W*i +: FSEL_W];
        assign out_next[i] = fen_reg[i] ? periph_out[fsel][i] : data_reg[i];
        assign oe_next[i] = fen_reg[i] ? periph_oe[fsel][i] : dir_reg[i];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out <= '0;
            pin_oe <= '0;
            periph_in <= '0;
        end else begin
            pin_out <= out_next;
            pin_oe <= oe_next;
            periph_in <= pin_in;
        end
    end

    // pin interrupt channels
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        ch_wr_t cw;
        assign cw = {wr_pend_reg && ch_hit && (int'(ch_idx) == c), addr_reg[5:0], hwdata};
        pin_irq_channel u_ch (
            .hclk(hclk),
            .hresetn(hresetn),
            .wr(cw),
            .pins(pin_in),
            .rd_off(addr_reg[5:0]),
            .rd_data(ch_rd[c]),
            .req(ch_req[c])
        );
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_irq <= '0;
        end else begin
            pin_irq <= ch_req;
        end
    end

    // read mux
    always_comb begin
        rd_mux = RST_WORD;
        unique case (addr_reg)
            OFF_DATA, OFF_DATA_SET, OFF_DATA_CLR, OFF_DATA_TGL: rd_mux = data_reg;
            OFF_DIR, OFF_DIR_SET, OFF_DIR_CLR: rd_mux = dir_reg;
            OFF_PIN_STATE: rd_mux = pin_in;
            OFF_IMASK: rd_mux = gmask_reg;
            OFF_ISTAT: rd_mux = gstat_reg;
            OFF_ISENS: rd_mux = gsens_reg;
            OFF_IBOTH: rd_mux = gboth_reg;
            OFF_FUNC_EN: rd_mux = fen_reg;
            OFF_FMUX_LO: rd_mux = fmux_lo_reg;
            OFF_FMUX_HI: rd_mux = fmux_hi_reg;
            default: begin
                if (ch_hit) begin
                    rd_mux = ch_rd[ch_idx[1:0]];
                end
            end
        endcase
    end

    // assertions
    property p_dir_set;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && addr_reg == OFF_DIR_SET) |=> dir_reg == ($past(dir_reg) | $past(hwdata));
    endproperty
    a_dir_set: assert property (p_dir_set) else $error("direction set wrong");

    property p_data_clr;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && addr_reg == OFF_DATA_CLR) |=> data_reg == ($past(data_reg) & ~$past(hwdata));
    endproperty
    a_data_clr: assert property (p_data_clr) else $error("data clear wrong");

    property p_gpio_oe;
        @(posedge hclk) disable iff (!hresetn)
        (fen_reg == RST_WORD) |=> pin_oe == $past(dir_reg);
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("gpio drive enable wrong");

    property p_mux0;
        @(posedge hclk) disable iff (!hresetn)
        (fen_reg[0] && fmux_lo_reg[1:0] == 2'h3) |=> pin_out[0] == $past(periph_out[3][0]);
    endproperty
    a_mux0: assert property (p_mux0) else $error("peripheral mux wrong");

    property p_level;
        @(posedge hclk) disable iff (!hresetn)
        (!gsens_reg[0] && !dir_reg[0]) |=> gstat_reg[0] == $past(pin_in[0]);
    endproperty
    a_level: assert property (p_level) else $error("level status wrong");

    property p_rise;
        @(posedge hclk) disable iff (!hresetn)
        (gsens_reg[0] && !dir_reg[0] && pin_in[0] && !src_prev_reg[0]) |=> gstat_reg[0];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed");

    property p_fall_ignored;
        @(posedge hclk) disable iff (!hresetn)
        (gsens_reg[0] && !gboth_reg[0] && !gstat_reg[0] && !dir_reg[0] && !pin_in[0]
         && src_prev_reg[0]) |=> !gstat_reg[0];
    endproperty
    a_fall_ignored: assert property (p_fall_ignored) else $error("falling edge taken");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        (|(gstat_reg & gmask_reg)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_rd_wait;
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && state_reg == BUS_READY) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");

    property p_data_tgl;
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && addr_reg == OFF_DATA_TGL) |=> data_reg == ($past(data_reg) ^ $past(hwdata));
    endproperty
    a_data_tgl: assert property (p_data_tgl) else $error("data toggle wrong");

    property p_pin_irq;
        @(posedge hclk) disable iff (!hresetn)
        ch_req[0] |=> pin_irq[0];
    endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("channel request not forwarded");

    property p_sw_trigger;
        @(posedge hclk) disable iff (!hresetn)
        (dir_reg[1] && gsens_reg[1] && data_reg[1] && !src_prev_reg[1]) |=> gstat_reg[1];
    endproperty
    a_sw_trigger: assert property (p_sw_trigger) else $error("software trigger missed");

    property p_cov_write;
        @(posedge hclk) disable iff (!hresetn) wr_pend_reg && addr_reg == OFF_DATA_SET;
    endproperty
    c_cov_write: cover property (p_cov_write);

    property p_cov_read;
        @(posedge hclk) disable iff (!hresetn) state_reg == BUS_RD_WAIT && ch_hit;
    endproperty
    c_cov_read: cover property (p_cov_read);

    property p_cov_irq;
        @(posedge hclk) disable iff (!hresetn) $rose(irq);
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_pin_irq;
        @(posedge hclk) disable iff (!hresetn) $rose(pin_irq[0]);
    endproperty
    c_cov_pin_irq: cover property (p_cov_pin_irq);
endmodule

// file: pin_pad_model.sv
// Purpose: pad side partner, resolves each pin from device and external drivers
// Assumes: external drive values change just after rising edges
// Notes: a pad that nobody drives shows a level that flips every cycle
`timescale 1ns/1ps
module pin_pad_model
    import gpio_pkg::*;
(
    input wire logic hclk,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] ext_val,
    input wire logic [NPINS-1:0] ext_en,
    output logic [NPINS-1:0] pin_in
);
    logic [NPINS-1:0] float_reg = '0;
    always_ff @(posedge hclk) begin
        float_reg <= ~float_reg;
    end
    // device drive wins, then external drive, else a changing level
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : float_reg[i]);
        end
    end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the gpio pin interrupt unit
// Assumes: single AHB-Lite master, pads resolved by the pad model
// Notes: random data from an lfsr with a fixed start value
`timescale 1ns/1ps
module testbench
    import gpio_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe, periph_in, ext_val, ext_en;
    logic [N_FUNC-1:0][NPINS-1:0] periph_out, periph_oe;
    logic [3:0] pin_irq;
    logic [31:0] seed = 32'h418e;
    int errors = 0;
    int n_tests = 0;

    always #2.5 hclk = ~hclk;

    gpio_pin_interrupt_unit #(.N_CH(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in), .irq(irq), .pin_irq(pin_irq)
    );

    pin_pad_model pads (
        .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in)
    );

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // expected data register after a plain, set, clear or toggle write
    function automatic logic [31:0] upd(input logic [31:0] c, input int op,
                                        input logic [31:0] d);
        case (op)
            0: return d;
            1: return c | d;
            2: return c & ~d;
            default: return c ^ d;
        endcase
    endfunction

    function automatic logic [31:0] pa(input logic [11:0] o);
        return {20'h0, o};
    endfunction

    function automatic logic [31:0] ca(input int c, input logic [5:0] o);
        return pa(CH_BASE) + 32'(c << CH_SHIFT) + {26'h0, o};
    endfunction

    task automatic results();
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // one single transfer: address phase, then data phase, each held until hready
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic pins(input logic [31:0] v);
        ext_val <= v;
        wt(4);
    endtask

    initial begin
        #100000;
        errors++;
        results();
    end

    initial begin
        logic [31:0] dv, ex, ev, m;
        int op;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = '0;
        ext_val = '0;
        ext_en = '1;
        for (int f = 0; f < N_FUNC; f++) begin
            periph_out[f] = rnd();
            periph_oe[f] = rnd();
        end
        wt(2);
        hresetn <= 1'b1;
        wt(1);
        chk({31'h0, hreadyout}, 32'h1);
        for (int a = 0; a < 'h140; a += 4)
            if (a < 'h40 || a >= 'h100) rd(32'(a), 32'h0);
        chk({31'h0, hresp}, 32'h0);
        // direction per pin, with set and clear aliases
        dv = rnd();
        m = rnd();
        wr(pa(OFF_DIR), dv);
        wr(pa(OFF_DIR_SET), m);
        dv = dv | m;
        m = rnd();
        wr(pa(OFF_DIR_CLR), m);
        dv = dv & ~m;
        rd(pa(OFF_DIR), dv);
        wt(2);
        chk(pin_oe, dv);
        // random data writes through all four aliases
        ex = '0;
        for (int i = 0; i < 16; i++) begin
            op = int'(rnd() & 32'h3);
            m = rnd();
            wr(pa(OFF_DATA) + 32'(4 * op), m);
            ex = upd(ex, op, m);
            rd(pa(OFF_DATA), ex);
        end
        ev = rnd();
        ext_val <= ev;
        wt(3);
        chk(pin_out & dv, ex & dv);
        rd(pa(OFF_PIN_STATE), (ex & dv) | (ev & ~dv));
        // every peripheral function on every pin
        wr(pa(OFF_FUNC_EN), '1);
        for (int f = 0; f < N_FUNC; f++) begin
            wr(pa(OFF_FMUX_LO), {16{2'(f)}});
            wr(pa(OFF_FMUX_HI), {16{2'(f)}});
            wt(3);
            chk(pin_out, periph_out[f]);
            chk(pin_oe, periph_oe[f]);
            chk(periph_in, (periph_out[f] & periph_oe[f]) | (ev & ~periph_oe[f]));
        end
        wr(pa(OFF_FUNC_EN), '0);
        wr(pa(OFF_DIR), '0);
        pins('0);
        // port interrupt: rising edge, both edges, mask, level, software trigger
        wr(pa(OFF_IMASK), 32'h1);
        wr(pa(OFF_ISENS), 32'h3);
        pins(32'h1);
        chk({31'h0, irq}, 32'h1);
        pins(32'h0);
        rd(pa(OFF_ISTAT), 32'h1);
        wr(pa(OFF_ISTAT), 32'h1);
        wt(3);
        chk({31'h0, irq}, 32'h0);
        pins(32'h1);
        rd(pa(OFF_ISTAT), 32'h1);
        wr(pa(OFF_ISTAT), 32'h1);
        pins(32'h0);
        rd(pa(OFF_ISTAT), 32'h0);
        wr(pa(OFF_IBOTH), 32'h1);
        wr(pa(OFF_IMASK), 32'h0);
        pins(32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(pa(OFF_ISTAT), 32'h1);
        pins(32'h0);
        rd(pa(OFF_ISTAT), 32'h1);
        wr(pa(OFF_ISTAT), 32'h1);
        wr(pa(OFF_ISENS), 32'h2);
        pins(32'h1);
        wr(pa(OFF_ISTAT), 32'h1);
        rd(pa(OFF_ISTAT), 32'h1);
        pins(32'h0);
        rd(pa(OFF_ISTAT), 32'h0);
        wr(pa(OFF_DATA), 32'h0);
        wr(pa(OFF_DIR), 32'h2);
        wr(pa(OFF_IMASK), 32'h2);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        wr(pa(OFF_DATA_SET), 32'h2);
        wt(3);
        chk({31'h0, irq}, 32'h1);
        wr(pa(OFF_DATA_CLR), 32'h2);
        wr(pa(OFF_ISTAT), 32'h2);
        wt(3);
        chk({31'h0, irq}, 32'h0);
        wr(pa(OFF_DIR), '0);
        // pin interrupt channels on half ports 1 and 3
        wr(ca(0, CH_ASSIGN), 32'h2);
        wr(ca(0, CH_MASK_SET), 32'h200);
        wr(ca(0, CH_EDGE_SET), 32'h200);
        wr(ca(1, CH_ASSIGN), 32'h8);
        wr(ca(1, CH_MASK_SET), 32'h100_0000);
        wr(ca(1, CH_EDGE_SET), 32'h100_0000);
        pins(32'h202);
        chk({28'h0, pin_irq}, 32'h1);
        rd(ca(0, CH_LATCH), 32'h200);
        rd(ca(0, CH_REQ), 32'h200);
        rd(ca(0, CH_PINS), 32'h202);
        pins(32'h100_0000);
        chk({28'h0, pin_irq}, 32'h3);
        wr(ca(0, CH_MASK_CLR), 32'h200);
        wt(3);
        chk({28'h0, pin_irq}, 32'h2);
        rd(ca(0, CH_LATCH), 32'h200);
        rd(ca(0, CH_MASK_SET), 32'h0);
        wr(ca(0, CH_LATCH), 32'h200);
        rd(ca(0, CH_LATCH), 32'h0);
        wr(ca(1, CH_REQ), 32'h100_0000);
        wt(3);
        chk({28'h0, pin_irq}, 32'h0);
        // active low level detection, also on a pin the port drives itself
        wr(ca(0, CH_MASK_SET), 32'h200);
        wr(ca(0, CH_EDGE_CLR), 32'h200);
        wr(ca(0, CH_INV_SET), 32'h200);
        wt(4);
        chk({28'h0, pin_irq}, 32'h1);
        pins(32'h200);
        chk({28'h0, pin_irq}, 32'h0);
        wr(pa(OFF_DATA), 32'h0);
        wr(pa(OFF_DIR), 32'h200);
        wt(5);
        chk({28'h0, pin_irq}, 32'h1);
        wr(pa(OFF_DIR), 32'h0);
        results();
    end
endmodule
